// >>> bench/board_model.sv
module board_model (
  input wire logic proc_rst_n_in,
  input wire logic proc_rst_oe_in,
  input wire logic init_n_in,
  output logic pci_clk_out,
  output logic proc_line_out,
  output logic init_to_cpu_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic kbd_soft_n;
  logic port92_soft_n;
  // free running bus clock
  // Offset keeps bus clock edges off host clock edges
  initial begin
    pci_clk_out = 1'b0;
    #10;
    forever #60 pci_clk_out = ~pci_clk_out;
  end
  assign proc_line_out = proc_rst_oe_in ? proc_rst_n_in : 1'b1;
  assign kbd_soft_n = 1'b1;
  assign port92_soft_n = 1'b1;
  assign init_to_cpu_n_out = init_n_in & kbd_soft_n & port92_soft_n;
  // board never drives the bus reset
endmodule // board_model

// >>> bench/tb_top.sv
module tb_top
  import reset_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BUS_C = 5;
  localparam int CPU_C = 10;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic power_good_in = 1'b0;
  logic shutdown_cycle_in = 1'b0;
  logic cfg_wr_in = 1'b0;
  logic cfg_rd_in = 1'b0;
  logic [7:0] cfg_addr_in = 8'h00;
  logic [7:0] cfg_wdata_in = 8'h00;
  logic [STRAP_W-1:0] bridge_strap_in = '0;
  logic [STRAP_W-1:0] dp_strap_in = '0;
  logic [7:0] cfg_rdata_out;
  logic [STRAP_W-1:0] bridge_strap_out;
  logic [STRAP_W-1:0] dp_strap_out;
  logic pci_clk, bus_n, req_n, prst_n, prst_oe, init_n, no_data, proc_line, init_cpu_n;
  int n_errors, compares, n_req, n_bus, n_init, n_nd, n_prl;
  logic [7:0] rd_val;

  always #20 core_clk_in = ~core_clk_in;

  chipset_reset_sequencer #(.BUS_RST_CYC(BUS_C), .CPU_RST_CYC(CPU_C)) u_dut (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .power_good_in(power_good_in),
    .pci_clock_in(pci_clk), .bridge_strap_in(bridge_strap_in), .dp_strap_in(dp_strap_in),
    .shutdown_cycle_in(shutdown_cycle_in), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
    .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
    .bus_reset_out_n(bus_n), .cpu_reset_request_n_out(req_n),
    .processor_reset_out_n(prst_n), .processor_reset_oe_out(prst_oe),
    .processor_init_n_out(init_n), .no_data_resp_out(no_data),
    .bridge_strap_out(bridge_strap_out), .dp_strap_out(dp_strap_out));

  board_model u_board (.proc_rst_n_in(prst_n), .proc_rst_oe_in(prst_oe), .init_n_in(init_n),
    .pci_clk_out(pci_clk), .proc_line_out(proc_line), .init_to_cpu_n_out(init_cpu_n));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic in_range(input int got, input int lo, input int hi);
    chk(32'(got >= lo && got <= hi), 32'h0000_0001);
  endtask

  // Samples after the calling edge and each later one, returns on an edge
  task automatic watch(input int cyc);
    n_req = 0;
    n_bus = 0;
    n_init = 0;
    n_nd = 0;
    n_prl = 0;
    repeat (cyc) begin
      #1;
      n_req += int'(req_n === 1'b0);
      n_bus += int'(bus_n === 1'b0);
      n_init += int'(init_cpu_n === 1'b0);
      n_nd += int'(no_data === 1'b1);
      n_prl += int'(proc_line === 1'b0);
      @(posedge core_clk_in);
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= addr;
    cfg_wdata_in <= data;
    @(posedge core_clk_in);
    cfg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge core_clk_in);
    cfg_rd_in <= 1'b1;
    cfg_addr_in <= addr;
    @(posedge core_clk_in);
    cfg_rd_in <= 1'b0;
    #1;
    data = cfg_rdata_out;
  endtask

  task automatic t_power;
    bridge_strap_in <= 4'hA;
    dp_strap_in <= 4'h5;
    watch(20);
    chk(n_req, 20);
    chk(n_bus, 20);
    power_good_in <= 1'b1;
    watch(40);
    in_range(n_req, CPU_C, CPU_C + 4);
    in_range(n_bus, BUS_C, BUS_C + 8);
    chk(proc_line, 1'b1);
    in_range(n_prl, CPU_C, CPU_C + 8);
    bridge_strap_in <= 4'h0;
    dp_strap_in <= 4'h0;
    watch(4);
    chk(bridge_strap_out, 4'hA);
    chk(dp_strap_out, 4'h5);
  endtask

  task automatic t_regs;
    rd(8'h93, rd_val);
    chk(rd_val, 8'h00);
    wr(8'h92, 8'hFF);
    rd(8'h92, rd_val);
    chk(rd_val, 8'h00);
    wr(8'h93, 8'h01);
    rd(8'h93, rd_val);
    chk(rd_val, 8'h01);
  endtask

  task automatic t_soft;
    wr(8'h93, 8'h04);
    watch(20);
    chk(n_init, 4);
    chk(n_req, 0);
    rd(8'h93, rd_val);
    chk(rd_val, 8'h04);
    wr(8'h93, 8'h00);
  endtask

  task automatic t_shut;
    @(posedge core_clk_in);
    shutdown_cycle_in <= 1'b1;
    @(posedge core_clk_in);
    shutdown_cycle_in <= 1'b0;
    watch(20);
    chk(n_nd, 1);
    chk(n_init, 4);
  endtask

  task automatic t_hard;
    dp_strap_in <= 4'h3;
    wr(8'h93, 8'h06);
    watch(40);
    chk(n_req, CPU_C);
    in_range(n_bus, BUS_C, BUS_C + 3);
    in_range(n_prl, CPU_C, CPU_C + 4);
    rd(8'h93, rd_val);
    chk(rd_val, 8'h00);
    chk(dp_strap_out, 4'h3);
    chk(bridge_strap_out, 4'hA);
  endtask

  task automatic t_bist;
    wr(8'h93, 8'h0C);
    watch(50);
    chk(n_req, CPU_C);
    in_range(n_bus, BUS_C, BUS_C + 3);
    in_range(n_init, CPU_C + 16, CPU_C + 18);
    rd(8'h93, rd_val);
    chk(rd_val, 8'h0C);
  endtask

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    t_power();
    t_regs();
    t_soft();
    t_shut();
    t_hard();
    t_bist();
    conclude();
  end

  initial begin
    #100us;
    n_errors++;
    conclude();
  end
endmodule // tb_top

// >>> pkg/reset_link_if.sv
interface reset_link_if;
  import reset_seq_pkg::*;
  logic cpu_reset_request_n;
  logic [STRAP_W-1:0] dp_strap_pin;
  logic proc_reset_level;
  logic proc_reset_oe;
  logic [STRAP_W-1:0] dp_strap_q;

  modport bridge (
    output cpu_reset_request_n,
    output dp_strap_pin,
    input proc_reset_level,
    input proc_reset_oe,
    input dp_strap_q
  );

  modport dp (
    input cpu_reset_request_n,
    input dp_strap_pin,
    output proc_reset_level,
    output proc_reset_oe,
    output dp_strap_q
  );
endinterface

// >>> pkg/reset_seq_pkg.sv
package reset_seq_pkg;

  // Clock and reset interval timing
  localparam int CLK_FREQ_KHZ = 25000;
  localparam int BUS_RST_TIME_US = 1000;
  localparam int CPU_RST_TIME_US = 2000;
  localparam int BUS_RST_CYCLES = (BUS_RST_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int CPU_RST_CYCLES = (CPU_RST_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int INIT_MIN_CLKS = 4;
  localparam int BIST_INIT_EXTRA_CLKS = 16;
  localparam int DP_RELEASE_CLKS = 2;

  // Turbo/reset control register
  localparam logic [7:0] REG_TURBO_RESET_CTRL = 8'h93;
  localparam int CTRL_W = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET_VAL = 4'h0;
  localparam int CTRL_TURBO_BIT = 0;
  localparam int CTRL_HARD_BIT = 1;
  localparam int CTRL_GO_BIT = 2;
  localparam int CTRL_BIST_BIT = 3;
  localparam int STAT_BUSY_BIT = 7;

  localparam int STRAP_W = 4;

  typedef enum logic [1:0] {
    BR_PWR_LOW = 2'b00,
    BR_HARD_SEQ = 2'b01,
    BR_RUN = 2'b10
  } bridge_state_t;

  typedef enum logic [1:0] {
    DP_HOLD = 2'b00,
    DP_WAIT = 2'b01,
    DP_RUN = 2'b10
  } dp_state_t;

endpackage

// >>> rtl/chipset_reset_sequencer.sv
// Summary of operation
// - While power good reads low, bus reset and CPU reset request are both held active.
// - After power good rises, bus reset holds 1 ms longer and CPU reset request 2 ms longer.
// - The data-path stage drives processor reset while it sees the request active.
// - Two host clocks after seeing the request high it stops driving processor reset.
// - Request and processor reset release on the host clock; bus reset moves on PCI clock.
// - A programmed hard reset holds the request at least 2 ms and bus reset 1 ms.
// - A programmed hard reset also clears the control register (bridge straps are kept, data-path straps re-latch), then processor reset follows.
// - Bridge straps are captured on the rising edge of power good.
// - The data-path stage resets its state from the request and latches straps as it rises.
// - A shutdown cycle gets a no-data reply, then init is held at least 4 host clocks.
// - A programmed soft reset holds init for at least 4 host clocks.
// - Self-test holds bus reset 1 ms, request 2 ms and init 2 ms plus 16 host clocks.
// - Host side logic runs on the host clock and bus reset logic follows the PCI clock.
module chipset_reset_sequencer
  import reset_seq_pkg::*;
#(
  parameter int BUS_RST_CYC = BUS_RST_CYCLES,
  parameter int CPU_RST_CYC = CPU_RST_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic power_good_in,
  input wire logic pci_clock_in,
  input wire logic [STRAP_W-1:0] bridge_strap_in,
  input wire logic [STRAP_W-1:0] dp_strap_in,
  input wire logic shutdown_cycle_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out,
  output logic bus_reset_out_n,
  output logic cpu_reset_request_n_out,
  output logic processor_reset_out_n,
  output logic processor_reset_oe_out,
  output logic processor_init_n_out,
  output logic no_data_resp_out,
  output logic [STRAP_W-1:0] bridge_strap_out,
  output logic [STRAP_W-1:0] dp_strap_out
);

  localparam int CW = $clog2(CPU_RST_CYC + BIST_INIT_EXTRA_CLKS + 1);
  localparam logic [CW-1:0] BUS_END = CW'(BUS_RST_CYC);
  localparam logic [CW-1:0] CPU_END = CW'(CPU_RST_CYC);
  localparam logic [CW-1:0] BIST_END = CW'(CPU_RST_CYC + BIST_INIT_EXTRA_CLKS);
  localparam logic [2:0] INIT_LOAD = 3'(INIT_MIN_CLKS);

  typedef struct packed {
    logic pg_s1;
    logic pg_s2;
    logic pg_s3;
    logic pclk_s1;
    logic pclk_s2;
    logic pclk_s3;
    logic [STRAP_W-1:0] strap_s1;
    logic [STRAP_W-1:0] strap_s2;
    logic [STRAP_W-1:0] strap;
    bridge_state_t state;
    logic [CW-1:0] cnt;
    logic [CW-1:0] bus_cnt;
    logic bist;
    logic [CTRL_W-1:0] ctrl;
    logic [2:0] init_cnt;
    logic no_data;
    logic bus_rst_n;
    logic cpu_req_n;
    logic init_n;
    logic [7:0] rdata;
  } br_reg_t;

  br_reg_t st_ff;
  br_reg_t nxt_st;
  logic pg_rise;
  logic pclk_rise;
  logic reg_hit;
  logic go_edge;
  logic soft_go;
  logic hard_go;
  logic bist_go;

  reset_link_if link ();

  function automatic logic hold_active(input bridge_state_t s, input logic [CW-1:0] c,
                                       input logic [CW-1:0] lim);
    hold_active = (s == BR_PWR_LOW) || (s == BR_HARD_SEQ && c < lim);
  endfunction

  assign pg_rise = st_ff.pg_s2 && !st_ff.pg_s3;
  assign pclk_rise = st_ff.pclk_s2 && !st_ff.pclk_s3;
  assign reg_hit = (cfg_addr_in == REG_TURBO_RESET_CTRL);
  assign go_edge = cfg_wr_in && reg_hit && cfg_wdata_in[CTRL_GO_BIT] && !st_ff.ctrl[CTRL_GO_BIT];
  assign bist_go = go_edge && cfg_wdata_in[CTRL_BIST_BIT] && st_ff.state == BR_RUN;
  assign hard_go = go_edge && !cfg_wdata_in[CTRL_BIST_BIT] && cfg_wdata_in[CTRL_HARD_BIT]
                   && st_ff.state == BR_RUN;
  assign soft_go = go_edge && !cfg_wdata_in[CTRL_BIST_BIT] && !cfg_wdata_in[CTRL_HARD_BIT];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pg_s1 = power_good_in;
    nxt_st.pg_s2 = st_ff.pg_s1;
    nxt_st.pg_s3 = st_ff.pg_s2;
    nxt_st.pclk_s1 = pci_clock_in;
    nxt_st.pclk_s2 = st_ff.pclk_s1;
    nxt_st.pclk_s3 = st_ff.pclk_s2;
    nxt_st.strap_s1 = bridge_strap_in;
    nxt_st.strap_s2 = st_ff.strap_s1;
    nxt_st.no_data = 1'b0;
    nxt_st.rdata = 8'h00;
    if (pg_rise) begin
      nxt_st.strap = st_ff.strap_s2;
    end
    if (cfg_wr_in && reg_hit) begin
      nxt_st.ctrl = cfg_wdata_in[CTRL_W-1:0];
    end
    if (shutdown_cycle_in) begin
      nxt_st.no_data = 1'b1;
    end
    if (st_ff.init_cnt != 3'd0) begin
      nxt_st.init_cnt = st_ff.init_cnt - 3'd1;
    end
    if (st_ff.no_data || soft_go) begin
      nxt_st.init_cnt = INIT_LOAD;
    end
    case (st_ff.state)
      BR_PWR_LOW: begin
        if (st_ff.pg_s2) begin
          nxt_st.state = BR_HARD_SEQ;
          nxt_st.cnt = '0;
        end
      end
      BR_HARD_SEQ: begin
        nxt_st.cnt = st_ff.cnt + CW'(1);
        if (nxt_st.cnt >= (st_ff.bist ? BIST_END : CPU_END)) begin
          nxt_st.state = BR_RUN;
          nxt_st.bist = 1'b0;
        end
      end
      BR_RUN: begin
        if (hard_go || bist_go) begin
          nxt_st.state = BR_HARD_SEQ;
          nxt_st.cnt = '0;
          nxt_st.bist = bist_go;
        end
      end
      default: nxt_st.state = BR_PWR_LOW;
    endcase
    if (hard_go) begin
      nxt_st.ctrl = CTRL_RESET_VAL;
    end
    if (!st_ff.pg_s2) begin
      nxt_st.state = BR_PWR_LOW;
      nxt_st.cnt = '0;
      nxt_st.bist = 1'b0;
    end
    nxt_st.cpu_req_n = !hold_active(nxt_st.state, nxt_st.cnt, CPU_END);
    if (st_ff.bus_rst_n) begin
      nxt_st.bus_cnt = '0;
    end else if (st_ff.bus_cnt < BUS_END) begin
      nxt_st.bus_cnt = st_ff.bus_cnt + CW'(1);
    end
    if (pclk_rise) begin
      nxt_st.bus_rst_n = !hold_active(nxt_st.state, nxt_st.cnt, BUS_END)
                         && (st_ff.bus_rst_n || nxt_st.bus_cnt >= BUS_END);
    end
    nxt_st.init_n = (nxt_st.init_cnt == 3'd0) && !(nxt_st.state == BR_HARD_SEQ && nxt_st.bist);
    if (cfg_rd_in && reg_hit) begin
      nxt_st.rdata[CTRL_W-1:0] = st_ff.ctrl;
      nxt_st.rdata[STAT_BUSY_BIT] = (st_ff.state != BR_RUN) || (st_ff.init_cnt != 3'd0);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
      st_ff.ctrl <= CTRL_RESET_VAL;
      st_ff.init_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.cpu_reset_request_n = st_ff.cpu_req_n;
  assign link.dp_strap_pin = dp_strap_in;

  data_path_reset_stage u_dp (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .link(link.dp)
  );

  assign cfg_rdata_out = st_ff.rdata;
  assign bus_reset_out_n = st_ff.bus_rst_n;
  assign cpu_reset_request_n_out = st_ff.cpu_req_n;
  assign processor_reset_out_n = link.proc_reset_level;
  assign processor_reset_oe_out = link.proc_reset_oe;
  assign processor_init_n_out = st_ff.init_n;
  assign no_data_resp_out = st_ff.no_data;
  assign bridge_strap_out = st_ff.strap;
  assign dp_strap_out = link.dp_strap_q;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_init_four;
    !st_ff.init_n [*4];
  endsequence

  sequence s_soft_write;
    soft_go && !st_ff.no_data;
  endsequence

  property p_hold_low;
    !st_ff.pg_s2 |=> !st_ff.cpu_req_n && st_ff.state == BR_PWR_LOW;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("request not held");

  property p_cpu_len;
    $rose(st_ff.cpu_req_n) |-> st_ff.cnt == CPU_END && st_ff.state != BR_PWR_LOW;
  endproperty
  a_cpu_len: assert property (p_cpu_len) else $error("request hold length");

  property p_bus_len;
    $rose(st_ff.bus_rst_n) |-> st_ff.cnt >= BUS_END;
  endproperty
  a_bus_len: assert property (p_bus_len) else $error("bus reset too short");

  property p_pci_sync;
    $changed(st_ff.bus_rst_n) |-> $past(pclk_rise);
  endproperty
  a_pci_sync: assert property (p_pci_sync) else $error("bus reset off PCI edge");

  property p_shutdown;
    shutdown_cycle_in |=> st_ff.no_data ##1 s_init_four;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown init");

  property p_soft;
    s_soft_write |=> s_init_four;
  endproperty
  a_soft: assert property (p_soft) else $error("soft init");

  property p_bist;
    st_ff.bist && st_ff.state == BR_HARD_SEQ && st_ff.cnt < BIST_END - CW'(1)
      |=> !st_ff.init_n;
  endproperty
  a_bist: assert property (p_bist) else $error("self-test init");

  property p_hard_clear;
    hard_go && st_ff.pg_s2 |=> st_ff.ctrl == CTRL_RESET_VAL && !st_ff.cpu_req_n;
  endproperty
  a_hard_clear: assert property (p_hard_clear) else $error("hard reset");

  property p_strap;
    pg_rise |=> st_ff.strap == $past(st_ff.strap_s2);
  endproperty
  a_strap: assert property (p_strap) else $error("bridge strap");

  property p_bus_min;
    $rose(st_ff.bus_rst_n) |-> st_ff.bus_cnt >= BUS_END;
  endproperty
  a_bus_min: assert property (p_bus_min) else $error("bus reset pulse short");

  property p_bus_pwr_low;
    st_ff.state == BR_PWR_LOW && pclk_rise |=> !st_ff.bus_rst_n;
  endproperty
  a_bus_pwr_low: assert property (p_bus_pwr_low) else $error("bus reset not held");

  property p_no_data_pulse;
    st_ff.no_data && !shutdown_cycle_in |=> !st_ff.no_data;
  endproperty
  a_no_data_pulse: assert property (p_no_data_pulse) else $error("no-data pulse long");

  property p_rdata_idle;
    !(cfg_rd_in && reg_hit) |=> st_ff.rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_bist_start;
    bist_go && st_ff.pg_s2 |=> !st_ff.cpu_req_n && !st_ff.init_n && st_ff.bist;
  endproperty
  a_bist_start: assert property (p_bist_start) else $error("self-test start");

  property p_dp_follow;
    $fell(st_ff.cpu_req_n) |=> link.proc_reset_oe && !link.proc_reset_level;
  endproperty
  a_dp_follow: assert property (p_dp_follow) else $error("processor reset not driven");

endmodule // chipset_reset_sequencer

// >>> rtl/data_path_reset_stage.sv
module data_path_reset_stage
  import reset_seq_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  reset_link_if.dp link
);

  localparam logic [1:0] RELEASE_LAST = 2'(DP_RELEASE_CLKS - 1);

  typedef struct packed {
    dp_state_t state;
    logic [1:0] cnt;
    logic req_q;
    logic [STRAP_W-1:0] strap_s1;
    logic [STRAP_W-1:0] strap_s2;
    logic [STRAP_W-1:0] strap_q;
    logic oe;
    logic level;
  } dp_reg_t;

  dp_reg_t st_ff;
  dp_reg_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.req_q = link.cpu_reset_request_n;
    nxt_st.strap_s1 = link.dp_strap_pin;
    nxt_st.strap_s2 = st_ff.strap_s1;
    if (link.cpu_reset_request_n && !st_ff.req_q) begin
      nxt_st.strap_q = st_ff.strap_s2;
    end
    case (st_ff.state)
      DP_HOLD: begin
        if (link.cpu_reset_request_n) begin
          nxt_st.state = DP_WAIT;
          nxt_st.cnt = 2'd0;
        end
      end
      DP_WAIT: begin
        if (st_ff.cnt == RELEASE_LAST) begin
          nxt_st.state = DP_RUN;
        end else begin
          nxt_st.cnt = st_ff.cnt + 2'd1;
        end
      end
      DP_RUN: begin
      end
      default: nxt_st.state = DP_HOLD;
    endcase
    if (!link.cpu_reset_request_n) begin
      nxt_st.state = DP_HOLD;
    end
    nxt_st.oe = (nxt_st.state != DP_RUN);
    nxt_st.level = !nxt_st.oe;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
      st_ff.oe <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.proc_reset_oe = st_ff.oe;
  assign link.proc_reset_level = st_ff.level;
  assign link.dp_strap_q = st_ff.strap_q;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_req_seen;
    st_ff.state == DP_HOLD && link.cpu_reset_request_n;
  endsequence

  property p_dp_hold;
    !link.cpu_reset_request_n |=> st_ff.oe && !st_ff.level;
  endproperty
  a_dp_hold: assert property (p_dp_hold) else $error("reset not driven");

  property p_dp_release;
    s_req_seen ##1 link.cpu_reset_request_n [*2] |-> st_ff.oe ##1 !st_ff.oe;
  endproperty
  a_dp_release: assert property (p_dp_release) else $error("release delay");

  property p_dp_strap;
    $rose(link.cpu_reset_request_n) |=> st_ff.strap_q == $past(st_ff.strap_s2);
  endproperty
  a_dp_strap: assert property (p_dp_strap) else $error("dp strap");

endmodule // data_path_reset_stage
